// [sim/tb_top.sv]
// Bench for the status and clock-select block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, e, rxd_in, txd_out;
    logic [7:0] got;
    int n_fail = 0;
    int checks = 0;
    always #20 pclk = ~pclk;
    ucs_status_clock ucs_status_clock_inst (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_in(rxd_in), .txd_out(txd_out),
        .external_timer_input(1'b0));
    ucs_remote ucs_remote_inst (.pclk(pclk), .txd_out(txd_out),
        .rxd_in(rxd_in), .got(got));
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask
    // One APB transfer, answer taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        r = prdata;
        e = pslverr;
        if (n >= 100) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Masked status read
    task automatic st(input logic [7:0] m, input logic [7:0] x);
        apb(1'b0, ucs_pkg::ADDR_STATUS, 32'h0);
        chk(r & {24'h0, m}, {24'h0, x});
    endtask
    task automatic stop_test;
        $display("n_fail %0d checks %0d", n_fail, checks);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #2000000;
        n_fail++;
        stop_test();
    end
    // Test sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        st(8'hff, 8'h00);
        apb(1'b1, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, ucs_pkg::ADDR_CSEL, 32'hdd);
        apb(1'b1, ucs_pkg::ADDR_CMD, 32'h05);
        st(8'h04, 8'h04);
        apb(1'b1, ucs_pkg::ADDR_DATA, 32'h55);
        st(8'h0c, 8'h04);
        repeat (220) @(posedge pclk);
        st(8'h0c, 8'h0c);
        chk({24'h0, got}, 32'h55);
        ucs_remote_inst.send(8'ha5, 1'b1);
        st(8'he3, 8'h01);
        apb(1'b0, ucs_pkg::ADDR_DATA, 32'h0);
        chk(r, 32'ha5);
        st(8'h01, 8'h00);
        ucs_remote_inst.send(8'h81, 1'b0);
        st(8'h41, 8'h41);
        apb(1'b1, ucs_pkg::ADDR_CMD, 32'h40);
        st(8'he1, 8'h01);
        apb(1'b0, ucs_pkg::ADDR_DATA, 32'h0);
        ucs_remote_inst.send(8'h00, 1'b0);
        st(8'hc1, 8'hc1);
        apb(1'b0, ucs_pkg::ADDR_DATA, 32'h0);
        st(8'h01, 8'h00);
        for (int i = 0; i < 5; i++) begin
            ucs_remote_inst.send(8'h10 + i[7:0], 1'b1);
            if (i == 1) st(8'h03, 8'h01);
            if (i == 2) st(8'h13, 8'h03);
        end
        st(8'h13, 8'h13);
        st(8'h10, 8'h10);
        for (int j = 0; j < 4; j++) begin
            apb(1'b0, ucs_pkg::ADDR_DATA, 32'h0);
            chk(r, 32'h10 + (j == 3 ? 32'h4 : 32'(j)));
        end
        apb(1'b1, ucs_pkg::ADDR_CMD, 32'h40);
        st(8'h10, 8'h00);
        // Even parity, 8 bits: stop slot carries a wrong parity bit
        apb(1'b1, ucs_pkg::ADDR_MODE, 32'h03);
        ucs_remote_inst.send(8'h03, 1'b1);
        st(8'he1, 8'h21);
        apb(1'b0, ucs_pkg::ADDR_DATA, 32'h0);
        chk(r, 32'h03);
        ucs_remote_inst.send(8'h33, 1'b1);
        apb(1'b1, ucs_pkg::ADDR_CMD, 32'h20);
        st(8'h03, 8'h00);
        apb(1'b1, ucs_pkg::ADDR_CMD, 32'h30);
        st(8'h0c, 8'h00);
        apb(1'b1, ucs_pkg::ADDR_DATA, 32'h3c);
        repeat (220) @(posedge pclk);
        chk({24'h0, got}, 32'h55);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire

// [sim/ucs_remote.sv]
// Remote serial end: sends frames to the receiver, captures sent ones
`default_nettype none
module ucs_remote (
    // Clock
    input wire logic pclk,
    // Serial lines
    input wire logic txd_out,
    output logic rxd_in,
    // Last character taken from the transmit line
    output logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CYC = 16;
    initial rxd_in = 1'b1;
    // One frame LSB first, stop bit may be left low
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] fr;
        fr = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            rxd_in <= fr[i];
            repeat (BIT_CYC - 1) @(posedge pclk);
        end
        // Break held low past the next character time
        if (d == 8'h00 && !stop) begin
            repeat (12 * BIT_CYC) @(posedge pclk);
        end
        @(posedge pclk);
        rxd_in <= 1'b1;
        repeat (3 * BIT_CYC) @(posedge pclk);
    endtask
    // Sample each sent frame at bit centres
    always begin
        @(negedge txd_out);
        repeat (BIT_CYC + BIT_CYC / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            got[i] = txd_out;
            repeat (BIT_CYC) @(posedge pclk);
        end
    end
endmodule // ucs_remote
`default_nettype wire

// [verilog/ucs_ifs.sv]
// Interfaces between the core and its tick and FIFO helpers
`default_nettype none
interface ucs_tick_if;
    logic [3:0] sel;
    logic [15:0] div;
    logic tick;
    logic x1;
    modport gen(input sel, input div, output tick, output x1);
    modport core(output sel, output div, input tick, input x1);
endinterface
interface ucs_fifo_if;
    logic push;
    logic pop;
    logic clear;
    logic clr_err;
    ucs_pkg::ucs_entry_t wr;
    ucs_pkg::ucs_entry_t head;
    logic [1:0] count;
    modport store(input push, input pop, input clear, input clr_err,
        input wr, output head, output count);
    modport core(output push, output pop, output clear, output clr_err,
        output wr, input head, input count);
endinterface
`default_nettype wire

// [verilog/ucs_pkg.sv]
// Shared constants and types for the status and clock-select block
`default_nettype none
package ucs_pkg;
    // Byte addresses of the registers
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CSEL = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0c;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_DIV = 8'h14;
    // Status bit positions
    localparam int ST_BRK = 7;
    localparam int ST_FE = 6;
    localparam int ST_PE = 5;
    localparam int ST_OVR = 4;
    localparam int ST_TXE = 3;
    localparam int ST_TXF = 2;
    localparam int ST_FULL = 1;
    localparam int ST_AVL = 0;
    // Clock select fields and codes
    localparam int RCS_LSB = 4;
    localparam int TCS_LSB = 0;
    localparam logic [3:0] CS_PRE = 4'hd;
    localparam logic [3:0] CS_DT16 = 4'he;
    localparam logic [3:0] CS_DT = 4'hf;
    localparam logic [7:0] CSEL_RESET = 8'h00;
    // Command fields and codes
    localparam int MISC_LSB = 4;
    localparam int TC_LSB = 2;
    localparam int RC_LSB = 0;
    localparam logic [2:0] MISC_RST_RX = 3'h2;
    localparam logic [2:0] MISC_RST_TX = 3'h3;
    localparam logic [2:0] MISC_RST_ERR = 3'h4;
    localparam logic [1:0] EN_CODE = 2'h1;
    localparam logic [1:0] DIS_CODE = 2'h2;
    // Mode: [1:0] length-5, [3:2] parity mode, [4] parity type
    localparam int MD_PM_LSB = 2;
    localparam int MD_PT = 4;
    localparam logic [1:0] PM_FORCE = 2'h1;
    localparam logic [1:0] PM_NONE = 2'h2;
    localparam logic [1:0] PM_MDROP = 2'h3;
    localparam logic [4:0] MODE_RESET = 5'h0b;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    // Oversampling, break recovery and FIFO size
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [1:0] BRK_HIGH_TICKS = 2'h2;
    localparam int FIFO_DEPTH = 3;
    localparam logic [1:0] FIFO_FULL_COUNT = 2'h3;
    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } ucs_entry_t;
endpackage
`default_nettype wire

// [verilog/ucs_rx_fifo.sv]
// Three-slot receive FIFO with status clear
`default_nettype none
module ucs_rx_fifo (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Core side
    ucs_fifo_if.store fq
);
    typedef struct packed {
        ucs_pkg::ucs_entry_t [ucs_pkg::FIFO_DEPTH-1:0] mem;
        logic [1:0] rd;
        logic [1:0] wr;
        logic [1:0] count;
    } ucs_fifo_t;
    ucs_fifo_t r, n;
    logic do_pop, do_push;

    function automatic logic [1:0] inc(input logic [1:0] p);
        inc = (p == 2'(ucs_pkg::FIFO_DEPTH - 1)) ? 2'h0 : p + 2'h1;
    endfunction

    // Pointer and slot update; a push lands after the status clear
    always_comb begin
        n = r;
        do_pop = fq.pop & (r.count != 2'h0);
        do_push = fq.push &
            ((r.count != ucs_pkg::FIFO_FULL_COUNT) | do_pop);
        if (fq.clr_err) begin
            for (int i = 0; i < ucs_pkg::FIFO_DEPTH; i++) begin
                n.mem[i].brk = 1'b0;
                n.mem[i].fe = 1'b0;
                n.mem[i].pe = 1'b0;
            end
        end
        if (do_pop) begin
            n.rd = inc(r.rd);
        end
        if (do_push) begin
            n.mem[r.wr] = fq.wr;
            n.wr = inc(r.wr);
        end
        n.count = r.count + {1'b0, do_push} - {1'b0, do_pop};
        if (fq.clear) begin
            n.rd = 2'h0;
            n.wr = 2'h0;
            n.count = 2'h0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign fq.head = r.mem[r.rd];
    assign fq.count = r.count;
endmodule // ucs_rx_fifo
`default_nettype wire

// [verilog/ucs_status_clock.sv]
// Serial channel status, clock select, receiver and transmitter core
`default_nettype none
module ucs_status_clock (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line and timer pin
    input wire logic rxd_in,
    output logic txd_out,
    input wire logic external_timer_input
);
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK
    } ucs_rx_state_t;

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic [7:0] csel;
        logic [4:0] mode;
        logic [15:0] div;
        logic [31:0] prdata;
        logic rx_en;
        ucs_rx_state_t st;
        logic [3:0] ph;
        logic [2:0] bit_n;
        logic [7:0] sh;
        logic par;
        logic [1:0] brk_hi;
        ucs_pkg::ucs_entry_t wt;
        logic wt_v;
        logic ovr;
        logic tx_en;
        logic [7:0] hold;
        logic hold_v;
        logic busy;
        logic [10:0] frame;
        logic [3:0] left;
        logic [3:0] tph;
        logic txe;
        logic txf;
    } ucs_core_t;

    ucs_core_t r, n;
    ucs_pkg::ucs_entry_t ent;
    logic acc, wr_en, mapped, cmd_wr, data_wr;
    logic rst_rx, rst_tx, rst_err, bit_due, done, push_ok, pop_ok, ovr_ev;
    logic load, full, avail, par_on;
    logic [1:0] pm, tc, rc;
    logic [2:0] bit_last;
    logic [3:0] rx_last, tx_last;
    logic [7:0] stat, dm;
    logic [10:0] f;
    logic [31:0] rdval;

    ucs_tick_if rtk();
    ucs_tick_if ttk();
    ucs_fifo_if fq();

    // Separate tick sources for receiver and transmitter
    ucs_tick_gen u_rx_tick (
        .pclk(pclk),
        .presetn(presetn),
        .external_timer_input(external_timer_input),
        .tk(rtk)
    );
    ucs_tick_gen u_tx_tick (
        .pclk(pclk),
        .presetn(presetn),
        .external_timer_input(external_timer_input),
        .tk(ttk)
    );
    ucs_rx_fifo u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .fq(fq)
    );

    // Clock codes feed each source on its own
    assign rtk.sel = r.csel[ucs_pkg::RCS_LSB +: 4];
    assign ttk.sel = r.csel[ucs_pkg::TCS_LSB +: 4];
    assign rtk.div = r.div;
    assign ttk.div = r.div;

    // Expected parity bit for even/odd or forced parity
    function automatic logic exp_par(input logic [7:0] d,
                                     input logic [4:0] md);
        if (md[ucs_pkg::MD_PM_LSB +: 2] == ucs_pkg::PM_FORCE) begin
            exp_par = md[ucs_pkg::MD_PT];
        end else begin
            exp_par = (^d) ^ md[ucs_pkg::MD_PT];
        end
    endfunction

    // Status word; head flags shown only with data waiting
    always_comb begin
        full = fq.count == ucs_pkg::FIFO_FULL_COUNT;
        avail = fq.count != 2'h0;
        stat = {avail & fq.head.brk, avail & fq.head.fe,
                avail & fq.head.pe, r.ovr, r.txe, r.txf, full, avail};
    end

    // Register read mux
    always_comb begin
        mapped = 1'b1;
        rdval = 32'h0;
        case (paddr)
            ucs_pkg::ADDR_STATUS: rdval = {24'h0, stat};
            ucs_pkg::ADDR_DATA: rdval = {24'h0, fq.head.data};
            ucs_pkg::ADDR_MODE: rdval = {27'h0, r.mode};
            ucs_pkg::ADDR_DIV: rdval = {16'h0, r.div};
            ucs_pkg::ADDR_CSEL, ucs_pkg::ADDR_CMD: rdval = 32'h0;
            default: mapped = 1'b0;
        endcase
    end

    // Next state of the whole core
    always_comb begin
        n = r;
        acc = psel & penable;
        wr_en = acc & pwrite & mapped;
        cmd_wr = wr_en & (paddr == ucs_pkg::ADDR_CMD);
        data_wr = wr_en & (paddr == ucs_pkg::ADDR_DATA);
        pop_ok = acc & ~pwrite & (paddr == ucs_pkg::ADDR_DATA) & avail;
        tc = pwdata[ucs_pkg::TC_LSB +: 2];
        rc = pwdata[ucs_pkg::RC_LSB +: 2];
        rst_rx = cmd_wr &
            (pwdata[ucs_pkg::MISC_LSB +: 3] == ucs_pkg::MISC_RST_RX);
        rst_tx = cmd_wr &
            (pwdata[ucs_pkg::MISC_LSB +: 3] == ucs_pkg::MISC_RST_TX);
        rst_err = cmd_wr &
            (pwdata[ucs_pkg::MISC_LSB +: 3] == ucs_pkg::MISC_RST_ERR);
        pm = r.mode[ucs_pkg::MD_PM_LSB +: 2];
        par_on = pm != ucs_pkg::PM_NONE;
        bit_last = 3'h4 + {1'b0, r.mode[1:0]};
        rx_last = rtk.x1 ? 4'h0 : ucs_pkg::OVS_LAST;
        tx_last = ttk.x1 ? 4'h0 : ucs_pkg::OVS_LAST;
        n.rx_s1 = rxd_in;
        n.rx_s2 = r.rx_s1;
        // Completed character and its flags
        ent.data = r.sh;
        ent.fe = ~r.rx_s2;
        ent.brk = (r.sh == 8'h0) & ~(par_on & r.par) &
            ~r.rx_s2;
        if (pm == ucs_pkg::PM_MDROP) begin
            ent.pe = r.par;
        end else begin
            ent.pe = ~pm[1] & (r.par != exp_par(r.sh, r.mode));
        end
        done = 1'b0;
        bit_due = r.ph == rx_last;
        // Receiver sequence on the receive tick
        if (!r.rx_en) begin
            n.st = RX_IDLE;
        end else if (rtk.tick) begin
            if (r.st == RX_DATA || r.st == RX_PAR || r.st == RX_STOP) begin
                n.ph = bit_due ? 4'h0 : r.ph + 4'h1;
            end
            case (r.st)
                RX_IDLE: if (!r.rx_s2) begin
                    n.sh = 8'h0;
                    n.bit_n = 3'h0;
                    n.ph = 4'h0;
                    n.st = rtk.x1 ? RX_DATA : RX_START;
                end
                RX_START: if (r.ph == ucs_pkg::OVS_MID) begin
                    n.ph = 4'h0;
                    n.st = r.rx_s2 ? RX_IDLE : RX_DATA;
                end else begin
                    n.ph = r.ph + 4'h1;
                end
                RX_DATA: if (bit_due) begin
                    n.sh[r.bit_n] = r.rx_s2;
                    n.bit_n = r.bit_n + 3'h1;
                    if (r.bit_n == bit_last) begin
                        n.st = par_on ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: if (bit_due) begin
                    n.par = r.rx_s2;
                    n.st = RX_STOP;
                end
                RX_STOP: if (bit_due) begin
                    done = 1'b1;
                    n.brk_hi = 2'h0;
                    n.st = ent.brk ? RX_BRK : RX_IDLE;
                end
                RX_BRK: if (!r.rx_s2) begin
                    n.brk_hi = 2'h0;
                end else if (r.brk_hi == ucs_pkg::BRK_HIGH_TICKS - 2'h1) begin
                    n.st = RX_IDLE;
                end else begin
                    n.brk_hi = r.brk_hi + 2'h1;
                end
                default: n.st = RX_IDLE;
            endcase
        end
        // Waiting character drains into the FIFO, overrun on collision
        push_ok = r.wt_v & (~full | pop_ok);
        ovr_ev = done & r.wt_v & ~push_ok;
        if (push_ok) begin
            n.wt_v = 1'b0;
        end
        if (rst_err) begin
            n.wt.brk = 1'b0;
            n.wt.fe = 1'b0;
            n.wt.pe = 1'b0;
            n.ovr = 1'b0;
        end
        if (done) begin
            n.wt = ent;
            n.wt_v = 1'b1;
        end
        if (ovr_ev) begin
            n.ovr = 1'b1;
        end
        // Transmit frame: start, data, optional parity, stop
        f = '1;
        f[0] = 1'b0;
        dm = 8'h0;
        for (int i = 0; i < 8; i++) begin
            if (3'(i) <= bit_last) begin
                f[i + 1] = r.hold[i];
                dm[i] = r.hold[i];
            end
        end
        if (par_on) begin
            f[{1'b0, bit_last} + 4'h2] = (pm == ucs_pkg::PM_MDROP) ?
                r.mode[ucs_pkg::MD_PT] : exp_par(dm, r.mode);
        end
        load = r.tx_en & ~r.busy & r.hold_v & ~data_wr;
        if (load) begin
            n.frame = f;
            n.left = {1'b0, bit_last} + 4'h3 + {3'h0, par_on};
            n.tph = 4'h0;
            n.busy = 1'b1;
            n.hold_v = 1'b0;
            n.txf = 1'b1;
            n.txe = 1'b0;
        end else if (r.busy && ttk.tick) begin
            if (r.tph == tx_last) begin
                n.tph = 4'h0;
                n.frame = {1'b1, r.frame[10:1]};
                n.left = r.left - 4'h1;
                if (r.left == 4'h1) begin
                    n.busy = 1'b0;
                    n.txe = r.tx_en & ~r.hold_v;
                end
            end else begin
                n.tph = r.tph + 4'h1;
            end
        end
        // Register writes
        if (data_wr) begin
            n.hold = pwdata[7:0];
            n.hold_v = 1'b1;
            n.txf = 1'b0;
        end
        if (wr_en && paddr == ucs_pkg::ADDR_CSEL) begin
            n.csel = pwdata[7:0];
        end
        if (wr_en && paddr == ucs_pkg::ADDR_MODE) begin
            n.mode = pwdata[4:0];
        end
        if (wr_en && paddr == ucs_pkg::ADDR_DIV) begin
            n.div = pwdata[15:0];
        end
        // Enable and disable fields
        if (cmd_wr && rc == ucs_pkg::EN_CODE) begin
            n.rx_en = 1'b1;
        end else if (cmd_wr && rc == ucs_pkg::DIS_CODE) begin
            n.rx_en = 1'b0;
        end
        if (cmd_wr && tc == ucs_pkg::EN_CODE && !r.tx_en) begin
            n.tx_en = 1'b1;
            n.txf = ~n.hold_v;
        end else if (cmd_wr && tc == ucs_pkg::DIS_CODE) begin
            n.tx_en = 1'b0;
            n.txe = 1'b0;
            n.txf = 1'b0;
        end
        // Receiver and transmitter resets
        if (rst_rx) begin
            n.rx_en = 1'b0;
            n.wt_v = 1'b0;
            n.st = RX_IDLE;
        end
        if (rst_tx) begin
            n.tx_en = 1'b0;
            n.txe = 1'b0;
            n.txf = 1'b0;
            n.busy = 1'b0;
            n.hold_v = 1'b0;
            n.frame = '1;
        end
        // Read data caught in the setup phase
        if (psel && !penable && !pwrite) begin
            n.prdata = rdval;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.rx_s1 <= 1'b1;
            r.rx_s2 <= 1'b1;
            r.csel <= ucs_pkg::CSEL_RESET;
            r.mode <= ucs_pkg::MODE_RESET;
            r.div <= ucs_pkg::DIV_RESET;
            r.st <= RX_IDLE;
            r.frame <= '1;
        end else begin
            r <= n;
        end
    end

    // FIFO hookup and outputs
    assign fq.push = push_ok;
    assign fq.pop = pop_ok;
    assign fq.clear = rst_rx;
    assign fq.clr_err = rst_err;
    assign fq.wr = r.wt;
    assign prdata = r.prdata;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign txd_out = r.frame[0];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_BRK_FLAG: assert property (done && r.sh == 8'h0 &&
        !par_on && !r.rx_s2 && !rst_rx |=> r.wt_v && r.wt.brk)
        else $error("break character not flagged");
    AST_BRK_INHIBIT: assert property (r.st == RX_BRK |-> !done)
        else $error("character taken during break recovery");
    AST_FRAME_ERR: assert property (done && !rst_rx |=>
        r.wt.fe == !$past(r.rx_s2))
        else $error("framing flag does not follow stop sample");
    AST_OVR_SET: assert property (ovr_ev |=> r.ovr)
        else $error("overrun not flagged");
    AST_OVR_KEEP: assert property (r.ovr && !rst_err |=> r.ovr)
        else $error("overrun dropped without reset command");
    AST_ERR_CLR: assert property (rst_err && !ovr_ev |=> !r.ovr)
        else $error("error reset left overrun set");
    AST_TXE_BUSY: assert property (r.busy |-> !r.txe)
        else $error("transmitter empty while shifting");
    AST_TXF_LOAD: assert property (load |=> r.txf && r.busy
        ##1 r.busy)
        else $error("holding free not set on move");
    AST_TX_OFF: assert property (!r.tx_en && !r.busy
        && !rst_tx |=> !r.busy [*2])
        else $error("disabled transmitter started a frame");
    AST_FULL_SET: assert property (push_ok && !pop_ok &&
        fq.count == 2'h2 && !rst_rx |=> stat[ucs_pkg::ST_FULL])
        else $error("full flag missing after last slot");
    AST_NOT_FULL: assert property (fq.count <= 2'h2 |->
        !stat[ucs_pkg::ST_FULL])
        else $error("full flag with free slot");
    AST_AVL_CLR: assert property (pop_ok && fq.count == 2'h1 &&
        !push_ok |=> !stat[ucs_pkg::ST_AVL])
        else $error("available flag after last read");
    AST_RST_RX: assert property (rst_rx |=> fq.count == 2'h0 &&
        !r.rx_en && !stat[ucs_pkg::ST_AVL])
        else $error("receiver reset incomplete");
    AST_RST_TX: assert property (rst_tx |=> !r.tx_en &&
        !r.txe && !r.txf)
        else $error("transmitter reset incomplete");
    AST_RSV_CODE: assert property ($past(rtk.sel) > 4'h0 &&
        $past(rtk.sel) < ucs_pkg::CS_PRE |-> !rtk.tick)
        else $error("tick from reserved clock code");

    COV_BREAK: cover property (done && ent.brk);
    COV_OVERRUN: cover property (ovr_ev);
    COV_TX_DONE: cover property (r.busy ##1 !r.busy && r.txe);
    COV_FULL: cover property (full && pop_ok);
endmodule // ucs_status_clock
`default_nettype wire

// [verilog/ucs_tick_gen.sv]
// Bit-clock tick source selected by one clock-select code
`default_nettype none
module ucs_tick_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Timer pin and tick port
    input wire logic external_timer_input,
    ucs_tick_if.gen tk
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [15:0] pcnt;
        logic tick;
        logic x1;
    } ucs_tick_t;
    ucs_tick_t r, n;
    logic pre_tick, pin_edge;

    // Prescaler, pin edge and source choice
    always_comb begin
        n = r;
        n.s1 = external_timer_input;
        n.s2 = r.s1;
        n.s3 = r.s2;
        pin_edge = r.s2 & ~r.s3;
        pre_tick = ({1'b0, r.pcnt} + 17'h1) >= {1'b0, tk.div};
        n.pcnt = pre_tick ? 16'h0 : r.pcnt + 16'h1;
        n.tick = 1'b0;
        n.x1 = 1'b0;
        case (tk.sel)
            ucs_pkg::CS_PRE: n.tick = pre_tick;
            ucs_pkg::CS_DT16: n.tick = pin_edge;
            ucs_pkg::CS_DT: begin
                n.tick = pin_edge;
                n.x1 = 1'b1;
            end
            default: n.tick = 1'b0; // Reserved: no clock
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tk.tick = r.tick;
    assign tk.x1 = r.x1;
endmodule // ucs_tick_gen
`default_nettype wire
